// [common/ccvs_pkg.sv]
package ccvs_pkg;

  // Address of the oscillator clock control register on the processor I/O bus.
  localparam logic [15:0] CCVS_CTRL_ADDR   = 16'hFF00;

  // Field positions inside the control register.
  localparam int          CCVS_VOLT_BIT    = 0;
  localparam int          CCVS_UNUSED_BIT  = 1;
  localparam int          CCVS_OSC_EN_BIT  = 2;
  localparam int          CCVS_CLK_SEL_BIT = 3;

  // Reset value of the control register.
  localparam logic [3:0]  CCVS_CTRL_RESET  = 4'h0;

  // CPU clock periods that make up one instruction cycle.
  localparam logic [1:0]  CCVS_INSTR_PERIODS = 2'h2;

  typedef struct packed {
    logic clk_sel;
    logic osc_en;
    logic unused;
    logic volt_sel;
  } ccvs_ctrl_t;

  typedef enum logic [1:0] {
    CCVS_MUX_SLOW = 2'b01,
    CCVS_MUX_FAST = 2'b10
  } ccvs_mux_state_t;

  function automatic logic ccvs_hit(input logic [15:0] addr);
    return addr == CCVS_CTRL_ADDR;
  endfunction : ccvs_hit

endpackage : ccvs_pkg

// [logic/ccvs_clock_mux.sv]
`timescale 1ns/10ps
module ccvs_clock_mux
  import ccvs_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic slow_osc_level,
  input  wire logic fast_osc_level,
  input  wire logic want_fast,
  output logic      cpu_clk,
  output logic      on_fast
);

  ccvs_mux_state_t state;
  ccvs_mux_state_t next_state;
  wire logic       both_low;
  wire logic       next_clk;

  // Switching only while both sources sit low keeps runt pulses off the CPU clock.
  assign both_low = !slow_osc_level && !fast_osc_level;

  always_comb begin
    next_state = state;
    unique case (state)
      CCVS_MUX_SLOW: begin
        if (want_fast && both_low) next_state = CCVS_MUX_FAST;
      end
      CCVS_MUX_FAST: begin
        if (!want_fast && both_low) next_state = CCVS_MUX_SLOW;
      end
      default: begin
        next_state = CCVS_MUX_SLOW;
      end
    endcase
  end

  assign next_clk = (next_state == CCVS_MUX_FAST) ? fast_osc_level : slow_osc_level;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= CCVS_MUX_SLOW;
      cpu_clk <= 1'b0;
      on_fast <= 1'b0;
    end else begin
      state   <= next_state;
      cpu_clk <= next_clk;
      on_fast <= next_state == CCVS_MUX_FAST;
    end
  end

  a_switch_at_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(on_fast) |-> !$past(slow_osc_level) && !$past(fast_osc_level))
    else $error("Clock source changed while an oscillator was high.");

  a_no_runt_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(on_fast) |-> !cpu_clk)
    else $error("Clock output was high at a source change.");

endmodule : ccvs_clock_mux

// [logic/ccvs_clock_control.sv]
`timescale 1ns/10ps
module ccvs_clock_control
  import ccvs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [3:0]  io_wdata,
  output logic      [3:0]  io_rdata,
  input  wire logic        slow_osc_is_rc,
  input  wire logic        fast_osc_fitted,
  input  wire logic        slow_osc_level,
  input  wire logic        fast_osc_level,
  output logic             cpu_clk,
  output logic             cpu_on_fast,
  output logic             fast_osc_run,
  output logic             core_supply_high,
  output logic             instr_strobe
);

  ccvs_ctrl_t ctrl;
  ccvs_ctrl_t next_ctrl;
  ccvs_ctrl_t wr_ctrl;
  wire logic  wr_hit;
  wire logic  rd_hit;
  wire logic  supply_high;
  wire logic  fast_allowed;
  wire logic  next_supply_high;
  wire logic  clk_rise;
  wire logic  next_strobe;
  logic       cpu_clk_prev;
  logic       half_done;

  assign wr_ctrl = ccvs_ctrl_t'(io_wdata);
  assign wr_hit  = io_wr && ccvs_hit(io_addr);
  assign rd_hit  = io_rd && ccvs_hit(io_addr);

  // With the RC slow oscillator the supply is a mask-option fact, not a software choice.
  assign next_supply_high = slow_osc_is_rc ? fast_osc_fitted
                                           : next_ctrl.volt_sel;
  assign supply_high      = core_supply_high;

  // The fast clock is refused only while the core sits low and the oscillator is stopped.
  assign fast_allowed = supply_high || ctrl.osc_en;

  always_comb begin
    next_ctrl = ctrl;
    if (wr_hit) begin
      next_ctrl.volt_sel = wr_ctrl.volt_sel;
      next_ctrl.osc_en   = wr_ctrl.osc_en;
      next_ctrl.unused   = 1'b0;
      next_ctrl.clk_sel  = wr_ctrl.clk_sel && (fast_allowed || ctrl.clk_sel);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl             <= ccvs_ctrl_t'(CCVS_CTRL_RESET);
      core_supply_high <= 1'b0;
      fast_osc_run     <= 1'b0;
    end else begin
      ctrl             <= next_ctrl;
      core_supply_high <= next_supply_high;
      fast_osc_run     <= next_ctrl.osc_en;
    end
  end

  // Reads of any other address return zero so a stray read cannot alias this register.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= 4'h0;
    end else if (io_rd) begin
      io_rdata <= rd_hit ? {ctrl.clk_sel, ctrl.osc_en, 1'b0, ctrl.volt_sel} : 4'h0;
    end
  end

  ccvs_clock_mux i_ccvs_clock_mux (
    .sys_clk        (sys_clk),
    .rst_n          (rst_n),
    .slow_osc_level (slow_osc_level),
    .fast_osc_level (fast_osc_level),
    .want_fast      (ctrl.clk_sel),
    .cpu_clk        (cpu_clk),
    .on_fast        (cpu_on_fast)
  );

  // One instruction cycle is marked on every second rising edge of the CPU clock.
  assign clk_rise    = cpu_clk && !cpu_clk_prev;
  assign next_strobe = clk_rise && half_done;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_prev <= 1'b0;
      half_done    <= 1'b0;
      instr_strobe <= 1'b0;
    end else begin
      cpu_clk_prev <= cpu_clk;
      instr_strobe <= next_strobe;
      if (clk_rise) begin
        half_done <= !half_done;
      end
    end
  end

  // Helper: rising edges of the CPU clock since the last instruction strobe.
  logic [1:0] rise_count;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_count <= 2'h0;
    end else if (instr_strobe) begin
      rise_count <= clk_rise ? 2'h1 : 2'h0;
    end else if (clk_rise && rise_count != 2'h3) begin
      rise_count <= rise_count + 2'h1;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (!rst_n);

  a_instr_two_periods: assert property (
    instr_strobe |-> rise_count == CCVS_INSTR_PERIODS)
    else $error("Instruction strobe not after two CPU clock periods.");

  a_strobe_one_cycle: assert property (
    instr_strobe |=> !instr_strobe)
    else $error("Instruction strobe lasted more than one cycle.");

  a_volt_write_crystal: assert property (
    wr_hit && !slow_osc_is_rc |=> core_supply_high == $past(io_wdata[CCVS_VOLT_BIT]))
    else $error("Core supply did not follow the written select bit.");

  a_crystal_supply_bit: assert property (
    !slow_osc_is_rc && $stable(slow_osc_is_rc) |-> core_supply_high == ctrl.volt_sel)
    else $error("Crystal core supply differs from the stored select bit.");

  a_rc_supply_fixed: assert property (
    slow_osc_is_rc && $stable(slow_osc_is_rc) && $stable(fast_osc_fitted)
      |-> ##1 core_supply_high == $past(fast_osc_fitted))
    else $error("RC supply level did not follow the fitted fast oscillator.");

  a_rc_zero_ignored: assert property (
    slow_osc_is_rc && fast_osc_fitted ##1 slow_osc_is_rc && fast_osc_fitted && wr_hit && !io_wdata[CCVS_VOLT_BIT]
      |=> core_supply_high)
    else $error("RC supply dropped after a write of zero.");

  a_volt_rc_stored: assert property (
    wr_hit && slow_osc_is_rc |=> ctrl.volt_sel == $past(io_wdata[CCVS_VOLT_BIT]))
    else $error("Supply select bit not stored with the RC oscillator.");

  a_osc_enable_write: assert property (
    wr_hit |=> fast_osc_run == $past(io_wdata[CCVS_OSC_EN_BIT]))
    else $error("Fast oscillator run did not follow the write.");

  a_run_matches_bit: assert property (
    fast_osc_run == ctrl.osc_en)
    else $error("Fast oscillator run differs from the stored enable bit.");

  a_write_other_ignored: assert property (
    !wr_hit |=> $stable(ctrl))
    else $error("Control register changed without a write.");

  a_clk_sel_refused: assert property (
    wr_hit && io_wdata[CCVS_CLK_SEL_BIT] && !core_supply_high && !ctrl.osc_en && !ctrl.clk_sel
      |=> !ctrl.clk_sel ##1 !cpu_on_fast)
    else $error("Fast clock select accepted while refused.");

  a_clk_sel_taken: assert property (
    wr_hit && io_wdata[CCVS_CLK_SEL_BIT] && (core_supply_high || ctrl.osc_en) |=> ctrl.clk_sel)
    else $error("Allowed fast clock select was not stored.");

  a_clk_sel_kept: assert property (
    wr_hit && io_wdata[CCVS_CLK_SEL_BIT] && ctrl.clk_sel |=> ctrl.clk_sel)
    else $error("Fast clock select dropped on a repeated write.");

  a_fast_needs_select: assert property (
    $rose(cpu_on_fast) |-> $past(ctrl.clk_sel))
    else $error("CPU moved to the fast clock without selection.");

  a_unused_reads_zero: assert property (
    $past(io_rd) |-> !io_rdata[CCVS_UNUSED_BIT])
    else $error("Unused bit read as one.");

  a_unused_stored_zero: assert property (
    wr_hit && io_wdata[CCVS_UNUSED_BIT] |=> !ctrl.unused)
    else $error("Unused bit was stored.");

  a_unmapped_read_zero: assert property (
    io_rd && !rd_hit |=> io_rdata == 4'h0)
    else $error("Read of another address did not return zero.");

  a_rdata_holds: assert property (
    !io_rd |=> $stable(io_rdata))
    else $error("Read data changed without a read.");

  a_read_matches: assert property (
    rd_hit |=> io_rdata == {$past(ctrl.clk_sel), $past(ctrl.osc_en), 1'b0, $past(ctrl.volt_sel)})
    else $error("Read data did not show the register.");

  a_slow_after_reset: assert property (
    !ctrl.clk_sel && !slow_osc_level && !fast_osc_level |=> !cpu_on_fast)
    else $error("CPU runs on the fast clock without selection.");

endmodule : ccvs_clock_control

// [verification/ccvs_clock_control_tb.sv]
`timescale 1ns/10ps
module ccvs_clock_control_tb;
  import ccvs_pkg::*;
  logic        sys_clk, rst_n, io_wr, io_rd, slow_osc_is_rc, fast_osc_fitted;
  logic        slow_osc_level, fast_osc_level, cpu_clk, cpu_on_fast;
  logic        fast_osc_run, core_supply_high, instr_strobe, last_clk;
  logic [15:0] io_addr;
  logic [3:0]  io_wdata, io_rdata;
  int          error_cnt, num_checks, rises, strobes;
  // The design does not time the settling waits, so they are scaled down here to keep the run short.
  localparam int SETTLE_TICKS = 20;

  ccvs_clock_control i_ccvs_clock_control (.sys_clk(sys_clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .slow_osc_is_rc(slow_osc_is_rc),
    .fast_osc_fitted(fast_osc_fitted), .slow_osc_level(slow_osc_level), .fast_osc_level(fast_osc_level),
    .cpu_clk(cpu_clk), .cpu_on_fast(cpu_on_fast), .fast_osc_run(fast_osc_run),
    .core_supply_high(core_supply_high), .instr_strobe(instr_strobe));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Edge counting runs beside the scenarios so the strobe ratio is judged over a whole stretch.
  always @(posedge sys_clk) begin
    last_clk <= cpu_clk;
    if (cpu_clk === 1'b1 && last_clk === 1'b0) rises++;
    if (instr_strobe === 1'b1) strobes++;
  end

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : ticks

  task automatic do_reset(input logic rc, input logic fitted);
    rst_n = 1'b0;
    slow_osc_is_rc = rc;
    fast_osc_fitted = fitted;
    slow_osc_level = 1'b0;
    fast_osc_level = 1'b0;
    ticks(4);
    rst_n = 1'b1;
    ticks(2);
  endtask : do_reset

  task automatic wr(input logic [15:0] addr, input logic [3:0] data);
    io_addr = addr;
    io_wdata = data;
    io_wr = 1'b1;
    ticks(1);
    io_wr = 1'b0;
    ticks(1);
  endtask : wr

  task automatic rd(input logic [15:0] addr, input logic [3:0] exp);
    io_addr = addr;
    io_rd = 1'b1;
    ticks(1);
    io_rd = 1'b0;
    check("io_rdata", {4'h0, exp}, {4'h0, io_rdata});
    ticks(1);
  endtask : rd

  task automatic test_crystal_switch;
    do_reset(1'b0, 1'b1);
    rd(CCVS_CTRL_ADDR, CCVS_CTRL_RESET);
    check("supply", 8'h00, {7'h0, core_supply_high});
    wr(CCVS_CTRL_ADDR, 4'hA);
    rd(CCVS_CTRL_ADDR, 4'h0);
    check("on_fast", 8'h00, {7'h0, cpu_on_fast});
    wr(CCVS_CTRL_ADDR, 4'h1);
    check("supply", 8'h01, {7'h0, core_supply_high});
    ticks(SETTLE_TICKS);
    wr(CCVS_CTRL_ADDR, 4'h5);
    rd(CCVS_CTRL_ADDR, 4'h5);
    check("osc_run", 8'h01, {7'h0, fast_osc_run});
    ticks(2 * SETTLE_TICKS);
    wr(CCVS_CTRL_ADDR, 4'hF);
    rd(CCVS_CTRL_ADDR, 4'hD);
    ticks(2);
    check("on_fast", 8'h01, {7'h0, cpu_on_fast});
    fast_osc_level = 1'b1;
    ticks(1);
    check("cpu_clk", 8'h01, {7'h0, cpu_clk});
    wr(CCVS_CTRL_ADDR, 4'h5);
    ticks(3);
    check("on_fast", 8'h01, {7'h0, cpu_on_fast});
    check("cpu_clk", 8'h01, {7'h0, cpu_clk});
    fast_osc_level = 1'b0;
    ticks(1);
    check("on_fast", 8'h00, {7'h0, cpu_on_fast});
    check("cpu_clk", 8'h00, {7'h0, cpu_clk});
    wr(CCVS_CTRL_ADDR, 4'h1);
    wr(CCVS_CTRL_ADDR, 4'h0);
    ticks(1);
    check("osc_run", 8'h00, {7'h0, fast_osc_run});
    check("supply", 8'h00, {7'h0, core_supply_high});
  endtask : test_crystal_switch

  task automatic test_unmapped;
    wr(16'hFF01, 4'hF);
    rd(16'hFF01, 4'h0);
    rd(CCVS_CTRL_ADDR, 4'h0);
  endtask : test_unmapped

  task automatic test_rc_modes;
    do_reset(1'b1, 1'b1);
    check("supply", 8'h01, {7'h0, core_supply_high});
    wr(CCVS_CTRL_ADDR, 4'h1);
    wr(CCVS_CTRL_ADDR, 4'h0);
    check("supply", 8'h01, {7'h0, core_supply_high});
    wr(CCVS_CTRL_ADDR, 4'hC);
    rd(CCVS_CTRL_ADDR, 4'hC);
    check("on_fast", 8'h01, {7'h0, cpu_on_fast});
    do_reset(1'b1, 1'b0);
    check("supply", 8'h00, {7'h0, core_supply_high});
  endtask : test_rc_modes

  task automatic test_strobe;
    do_reset(1'b0, 1'b0);
    rises = 0;
    strobes = 0;
    repeat (40) begin
      slow_osc_level = ~slow_osc_level;
      ticks(2);
    end
    ticks(3);
    check("rises", 8'd20, rises[7:0]);
    check("strobes", 8'd10, strobes[7:0]);
  endtask : test_strobe

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    rst_n = 1'b0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 4'h0;
    slow_osc_is_rc = 1'b0;
    fast_osc_fitted = 1'b1;
    slow_osc_level = 1'b0;
    fast_osc_level = 1'b0;
    test_crystal_switch();
    test_unmapped();
    test_rc_modes();
    test_strobe();
    complete_run();
  end

  // The scenarios take well under a thousand cycles, so this span only fires on a hang.
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
endmodule : ccvs_clock_control_tb
